/* hdl/pfbw_writer.sv */
// Program flash block writer: holding registers, unlock, timed long write
`timescale 1ns/1ps
`default_nettype none
module pfbw_writer #(
  parameter int unsigned WRITE_CYCLES = pfbw_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // Core stall
  output logic                      core_stall_o,
  // Flash array programming port
  output pfbw_pkg::pfbw_prog_s      prog_o
);

  localparam int unsigned AW = pfbw_pkg::FLASH_AW;
  localparam int unsigned IW = $clog2(pfbw_pkg::BLOCK_BYTES);

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic       req;
  logic       wr;
  logic       wr_ctrl;
  logic       wr_unlock;
  logic       wr_ptr;
  logic       wr_tbl;
  logic       mapped;

  // Single-cycle strobe per access; ack gap guards against repeats
  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr        = req && wb_we_i && wb_sel_i[0];
  assign wr_ctrl   = wr && wb_adr_i == pfbw_pkg::ADDR_CONTROL;
  assign wr_unlock = wr && wb_adr_i == pfbw_pkg::ADDR_UNLOCK;
  assign wr_ptr    = wr && wb_adr_i == pfbw_pkg::ADDR_TBLPTR;
  assign wr_tbl    = wr && wb_adr_i == pfbw_pkg::ADDR_TBLWRITE;
  assign mapped    = wb_adr_i == pfbw_pkg::ADDR_CONTROL || wb_adr_i == pfbw_pkg::ADDR_UNLOCK ||
                     wb_adr_i == pfbw_pkg::ADDR_TBLPTR  || wb_adr_i == pfbw_pkg::ADDR_TBLWRITE;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [7:0]    holding_q [pfbw_pkg::BLOCK_BYTES];
  logic [AW-1:0] tblptr_q;
  logic          pgm_sel_q;
  logic          cfg_sel_q;
  logic          write_enable_bit_q;
  logic          wr_start_q;
  logic          armed;
  logic          tmr_busy;
  logic          tmr_done;
  logic          launch;
  logic          busy;

  function automatic logic [IW-1:0] slot_of(input logic [AW-1:0] ptr);
    slot_of = ptr[IW-1:0];
  endfunction : slot_of

  pfbw_unlock u_unlock (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .unlock_we_i   (wr_unlock),
    .unlock_data_i (wb_dat_i[7:0]),
    .other_we_i    (launch || (wr && !wr_unlock && !wr_ctrl)),
    .armed_o       (armed)
  );

  pfbw_timer #(
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (launch),
    .busy_o  (tmr_busy),
    .done_o  (tmr_done)
  );

  // Start only from an armed unlock with write enable held or written now
  assign launch = wr_ctrl && wb_dat_i[pfbw_pkg::BIT_WRITE_START] && armed && !wr_start_q &&
                  (write_enable_bit_q || wb_dat_i[pfbw_pkg::BIT_WRITE_EN]) &&
                  wb_dat_i[pfbw_pkg::BIT_PGM_SEL] && !wb_dat_i[pfbw_pkg::BIT_CFG_SEL];
  assign busy   = wr_start_q || tmr_busy;

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pgm_sel_q <= pfbw_pkg::CONTROL_RESET[pfbw_pkg::BIT_PGM_SEL];
      cfg_sel_q <= pfbw_pkg::CONTROL_RESET[pfbw_pkg::BIT_CFG_SEL];
      write_enable_bit_q    <= pfbw_pkg::CONTROL_RESET[pfbw_pkg::BIT_WRITE_EN];
    end else if (wr_ctrl && !busy) begin
      pgm_sel_q <= wb_dat_i[pfbw_pkg::BIT_PGM_SEL];
      cfg_sel_q <= wb_dat_i[pfbw_pkg::BIT_CFG_SEL];
      write_enable_bit_q    <= wb_dat_i[pfbw_pkg::BIT_WRITE_EN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_start_q <= pfbw_pkg::CONTROL_RESET[pfbw_pkg::BIT_WRITE_START];
    end else if (tmr_done) begin
      wr_start_q <= 1'b0;
    end else if (launch) begin
      wr_start_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Table pointer and holding registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tblptr_q <= '0;
    end else if (busy) begin
      tblptr_q <= tblptr_q;
    end else if (wr_ptr) begin
      tblptr_q <= wb_dat_i[AW-1:0];
    end else if (wr_tbl && wb_dat_i[pfbw_pkg::BIT_AUTO_INC]) begin
      tblptr_q <= tblptr_q + AW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < pfbw_pkg::BLOCK_BYTES; i++) begin
        holding_q[i] <= 8'h00;
      end
    end else if (wr_tbl && !busy) begin
      // Short write: only the holding register changes, plus the pointer when BIT_AUTO_INC is set
      holding_q[slot_of(tblptr_q)] <= wb_dat_i[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Flash programming request and stall
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_o <= '0;
    end else begin
      prog_o.start <= launch;
      if (launch) begin
        // Block address taken from the pointer's upper bits
        prog_o.block_addr <= {tblptr_q[AW-1:IW], IW'(0)};
        for (int i = 0; i < pfbw_pkg::BLOCK_BYTES; i++) begin
          prog_o.data[i*8 +: 8] <= holding_q[i];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_stall_o <= 1'b0;
    end else begin
      core_stall_o <= launch || (tmr_busy && !tmr_done);
    end
  end

  // ---------------------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= '0;
      if (req && !wb_we_i && mapped) begin
        case (wb_adr_i)
          pfbw_pkg::ADDR_CONTROL: begin
            wb_dat_o[pfbw_pkg::BIT_PGM_SEL]     <= pgm_sel_q;
            wb_dat_o[pfbw_pkg::BIT_CFG_SEL]     <= cfg_sel_q;
            wb_dat_o[pfbw_pkg::BIT_WRITE_EN]    <= write_enable_bit_q;
            wb_dat_o[pfbw_pkg::BIT_WRITE_START] <= wr_start_q;
          end
          pfbw_pkg::ADDR_TBLPTR: begin
            wb_dat_o[AW-1:0] <= tblptr_q;
          end
          pfbw_pkg::ADDR_TBLWRITE: begin
            wb_dat_o[7:0] <= holding_q[slot_of(tblptr_q)];
          end
          default: begin
            wb_dat_o <= '0;
          end
        endcase
      end
    end
  end

endmodule : pfbw_writer
`default_nettype wire

/* hdl/pfbw_pkg.sv */
// Package: constants, register map and types of the program flash block writer
package pfbw_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned BLOCK_BYTES  = 8;
  localparam int unsigned BLOCK_WORDS  = 4;
  localparam int unsigned ROW_BYTES    = 64;
  localparam int unsigned FLASH_AW     = 14;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned WRITE_US     = 2000;
  localparam int unsigned WRITE_CYCLES = (CLK_HZ / 1_000_000) * WRITE_US;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses, Wishbone word aligned)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL  = 4'h0;
  localparam logic [3:0] ADDR_UNLOCK   = 4'h4;
  localparam logic [3:0] ADDR_TBLPTR   = 4'h8;
  localparam logic [3:0] ADDR_TBLWRITE = 4'hc;

  // Control register fields
  localparam int unsigned BIT_WRITE_START = 1;
  localparam int unsigned BIT_WRITE_EN    = 2;
  localparam int unsigned BIT_CFG_SEL     = 6;
  localparam int unsigned BIT_PGM_SEL     = 7;

  // Table-write register fields
  localparam int unsigned BIT_AUTO_INC    = 8;

  // Unlock keys
  localparam logic [7:0] UNLOCK_KEY1   = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2   = 8'haa;

  localparam logic [7:0] CONTROL_RESET = 8'h00;

  typedef enum logic [1:0] {
    PFBW_UNLOCK_IDLE,
    PFBW_UNLOCK_KEY1,
    PFBW_UNLOCK_ARMED
  } pfbw_unlock_e;

  // Request to the flash array
  typedef struct packed {
    logic                              start;
    logic [FLASH_AW-1:0]               block_addr;
    logic [BLOCK_BYTES*8-1:0]          data;
  } pfbw_prog_s;

endpackage : pfbw_pkg

/* hdl/pfbw_unlock.sv */
// Two-write unlock sequence detector for the write-start bit
`timescale 1ns/1ps
`default_nettype none
module pfbw_unlock (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Unlock register write strobe
  input  wire logic       unlock_we_i,
  input  wire logic [7:0] unlock_data_i,
  // Any other register write, except a control write that does not launch, breaks the sequence
  input  wire logic       other_we_i,
  // Armed after 55h then AAh with no write in between other than a control write
  output logic            armed_o
);

  pfbw_pkg::pfbw_unlock_e state_q;

  // ---------------------------------------------------------------------------
  // Sequence tracker
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= pfbw_pkg::PFBW_UNLOCK_IDLE;
    end else if (unlock_we_i) begin
      case (state_q)
        pfbw_pkg::PFBW_UNLOCK_IDLE: begin
          if (unlock_data_i == pfbw_pkg::UNLOCK_KEY1) begin
            state_q <= pfbw_pkg::PFBW_UNLOCK_KEY1;
          end
        end
        pfbw_pkg::PFBW_UNLOCK_KEY1: begin
          if (unlock_data_i == pfbw_pkg::UNLOCK_KEY2) begin
            state_q <= pfbw_pkg::PFBW_UNLOCK_ARMED;
          end else if (unlock_data_i == pfbw_pkg::UNLOCK_KEY1) begin
            state_q <= pfbw_pkg::PFBW_UNLOCK_KEY1;
          end else begin
            state_q <= pfbw_pkg::PFBW_UNLOCK_IDLE;
          end
        end
        default: begin
          state_q <= (unlock_data_i == pfbw_pkg::UNLOCK_KEY1) ?
                     pfbw_pkg::PFBW_UNLOCK_KEY1 : pfbw_pkg::PFBW_UNLOCK_IDLE;
        end
      endcase
    end else if (other_we_i) begin
      // Only control writes that do not launch may come between unlock and start write
      state_q <= pfbw_pkg::PFBW_UNLOCK_IDLE;
    end
  end

  assign armed_o = (state_q == pfbw_pkg::PFBW_UNLOCK_ARMED);

endmodule : pfbw_unlock
`default_nettype wire

/* hdl/pfbw_timer.sv */
// Internal programming timer that sets the long write duration
`timescale 1ns/1ps
`default_nettype none
module pfbw_timer #(
  parameter int unsigned CYCLES = pfbw_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_q;

  // ---------------------------------------------------------------------------
  // Down counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else if (start_i && count_q == '0) begin
      count_q <= CW'(CYCLES);
    end else if (count_q != '0) begin
      count_q <= count_q - CW'(1);
    end
  end

  // Last count: a registered flag would add one stall cycle
  assign done_o = (count_q == CW'(1));

  assign busy_o = (count_q != '0);

endmodule : pfbw_timer
`default_nettype wire

/* verif/pfbw_props.sv */
// Checker of bus timing and long write behaviour of the block writer
`timescale 1ns/1ps
`default_nettype none
module pfbw_props #(
  parameter int unsigned WRITE_CYCLES = pfbw_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  // Bus
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [3:0]           wb_adr_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  // Stall and flash port
  input wire logic                 core_stall_o,
  input wire pfbw_pkg::pfbw_prog_s prog_o
);
  // ---------------------------------------------------------------------------
  // Stall length counter
  // ---------------------------------------------------------------------------
  logic [31:0] stall_cnt_q;
  logic        start_wr;
  assign start_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == pfbw_pkg::ADDR_CONTROL &&
                    wb_dat_i[pfbw_pkg::BIT_WRITE_START];
  always_ff @(posedge clk_i) begin
    if (rst_i || !core_stall_o) stall_cnt_q <= 32'h0;
    else stall_cnt_q <= stall_cnt_q + 32'h1;
  end
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_start_cause: assert property (prog_o.start |-> $past(start_wr))
    else $error("launch without start write");
  a_stall_start: assert property ($rose(core_stall_o) |-> prog_o.start)
    else $error("stall without launch");
  a_launch_idle: assert property (prog_o.start |-> !$past(core_stall_o))
    else $error("launch during long write");
  a_block_align: assert property (prog_o.start |-> prog_o.block_addr[2:0] == 3'h0)
    else $error("block address not aligned");
  a_stall_length: assert property ($fell(core_stall_o) |-> stall_cnt_q == WRITE_CYCLES)
    else $error("stall length wrong");
  a_stall_bound: assert property (core_stall_o |-> stall_cnt_q < WRITE_CYCLES)
    else $error("stall overruns");
  c_launch: cover property (prog_o.start);
  c_finish: cover property ($fell(core_stall_o));
  c_busy_ack: cover property (wb_ack_o && core_stall_o);
endmodule : pfbw_props
bind pfbw_writer pfbw_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_stall_o(core_stall_o), .prog_o(prog_o)
);
`default_nettype wire

/* verif/pfbw_core_model.sv */
// Processor core model issuing table writes and control writes
`timescale 1ns/1ps
`default_nettype none
module pfbw_core_model (
  // Clock
  input  wire logic        clk_i,
  // Bus master
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [3:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i,
  // Wait bound used up
  output logic             hang_o
);
  initial begin
    {wb_cyc_o, wb_stb_o, wb_we_o, hang_o} = 4'h0;
    wb_adr_o = 4'h0;
    wb_sel_o = 4'h1;
    wb_dat_o = 32'h0;
  end
  // Called just after a rising edge; request held until ack is sampled
  task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'h3, we};
    wb_adr_o <= adr;
    wb_dat_o <= wd;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_i);
      if (wb_ack_i === 1'b1) break;
    end
    if (k == 50) hang_o <= 1'b1;
    rd = wb_dat_i;
    {wb_cyc_o, wb_stb_o} <= 2'h0;
    @(posedge clk_i);
  endtask : xfer
  task automatic fill(input logic [13:0] base, input logic [63:0] blk);
    logic [31:0] d;
    xfer(1'b1, pfbw_pkg::ADDR_TBLPTR, {18'h0, base}, d);
    for (int i = 0; i < 8; i++) xfer(1'b1, pfbw_pkg::ADDR_TBLWRITE, {23'h0, i < 7, blk[8*i +: 8]}, d);
  endtask : fill
  task automatic launch(input logic [7:0] ctl);
    logic [31:0] d;
    xfer(1'b1, pfbw_pkg::ADDR_UNLOCK, {24'h0, pfbw_pkg::UNLOCK_KEY1}, d);
    xfer(1'b1, pfbw_pkg::ADDR_UNLOCK, {24'h0, pfbw_pkg::UNLOCK_KEY2}, d);
    xfer(1'b1, pfbw_pkg::ADDR_CONTROL, {24'h0, ctl}, d);
  endtask : launch
endmodule : pfbw_core_model
`default_nettype wire

/* verif/pfbw_flash_model.sv */
// Flash array model capturing block programming requests
`timescale 1ns/1ps
`default_nettype none
module pfbw_flash_model (
  // Clock and request
  input  wire logic                 clk_i,
  input  wire pfbw_pkg::pfbw_prog_s prog_i,
  // Count of blocks taken and last block taken
  output int                        n_blk_o,
  output logic [13:0]               addr_o,
  output logic [63:0]               data_o
);
  initial n_blk_o = 0;
  always @(posedge clk_i) begin
    if (prog_i.start === 1'b1) begin
      n_blk_o <= n_blk_o + 1;
      addr_o <= prog_i.block_addr;
      data_o <= prog_i.data;
    end
  end
endmodule : pfbw_flash_model
`default_nettype wire

/* verif/pfbw_writer_tb.sv */
// Testbench of the program flash block writer
`timescale 1ns/1ps
`default_nettype none
module pfbw_writer_tb;
  // ---------------------------------------------------------------------------
  // Signals and models
  // ---------------------------------------------------------------------------
  localparam int unsigned WC  = 20;
  localparam logic [7:0]  PGM = 8'h1 << pfbw_pkg::BIT_PGM_SEL;
  localparam logic [7:0]  CTL = PGM | (8'h1 << pfbw_pkg::BIT_WRITE_EN);
  localparam logic [7:0]  GO  = 8'h1 << pfbw_pkg::BIT_WRITE_START;
  localparam logic [7:0]  CFG = 8'h1 << pfbw_pkg::BIT_CFG_SEL;
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 cyc, stb, we, ack, stall, hang;
  logic [3:0]           adr, sel;
  logic [31:0]          wdat, rdat, rd;
  logic [13:0]          f_addr, base, row;
  logic [63:0]          f_data, blk;
  logic [63:0]          exp_q[$];
  logic [31:0]          lfsr = 32'ha1c1;
  logic [7:0]           first;
  pfbw_pkg::pfbw_prog_s prog;
  int                   n_blk, cyc_n = 0, t0, miscompares = 0, n_tests = 0;
  always #12.5 clk_i = ~clk_i;
  // Counts stalled cycles only
  always @(posedge clk_i) cyc_n <= cyc_n + int'(stall === 1'b1);
  pfbw_writer #(.WRITE_CYCLES(WC)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .core_stall_o(stall), .prog_o(prog));
  pfbw_core_model u_core (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
    .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack), .hang_o(hang));
  pfbw_flash_model u_flash (.clk_i(clk_i), .prog_i(prog), .n_blk_o(n_blk), .addr_o(f_addr), .data_o(f_data));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  always @(posedge clk_i) begin
    if (hang === 1'b1) begin
      miscompares++;
      finish_test();
    end
  end
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    u_core.xfer(1'b0, pfbw_pkg::ADDR_CONTROL, 32'h0, rd);
    chk("control reset", rd, {24'h0, pfbw_pkg::CONTROL_RESET});
    u_core.xfer(1'b0, 4'h2, 32'h0, rd);
    chk("unmapped read", rd, 64'h0);
    // Refused starts: no unlock, broken unlock, enable clear, config space
    for (int k = 0; k < 4; k++) begin
      first = (k == 2) ? PGM : CTL;
      u_core.xfer(1'b1, pfbw_pkg::ADDR_CONTROL, {24'h0, first}, rd);
      if (k != 0) u_core.xfer(1'b1, pfbw_pkg::ADDR_UNLOCK, {24'h0, pfbw_pkg::UNLOCK_KEY1}, rd);
      if (k == 1) u_core.xfer(1'b1, pfbw_pkg::ADDR_TBLPTR, 32'h0, rd);
      if (k != 0) u_core.xfer(1'b1, pfbw_pkg::ADDR_UNLOCK, {24'h0, pfbw_pkg::UNLOCK_KEY2}, rd);
      u_core.xfer(1'b1, pfbw_pkg::ADDR_CONTROL, {24'h0, first | GO | ((k == 3) ? CFG : 8'h0)}, rd);
      chk("no stall", stall, 1'b0);
      chk("no launch", n_blk, 0);
      u_core.xfer(1'b0, pfbw_pkg::ADDR_CONTROL, 32'h0, rd);
      chk("control kept", rd, {24'h0, first | ((k == 3) ? CFG : 8'h0)});
    end
    // One full row, block by block, with random data
    lfsr = next_rand(lfsr);
    row = {lfsr[13:6], 6'h0};
    for (int b = 0; b < 8; b++) begin
      base = row | {8'h0, 3'(b), 3'h0};
      lfsr = next_rand(lfsr);
      blk[31:0] = lfsr;
      lfsr = next_rand(lfsr);
      blk[63:32] = lfsr;
      exp_q.push_back(blk);
      u_core.fill(base, blk);
      u_core.xfer(1'b0, pfbw_pkg::ADDR_TBLWRITE, 32'h0, rd);
      chk("holding byte", rd, {56'h0, blk[63:56]});
      t0 = cyc_n;
      u_core.launch(CTL | GO);
      // Busy write must not move the pointer
      u_core.xfer(1'b1, pfbw_pkg::ADDR_TBLPTR, {18'h0, base ^ 14'h8}, rd);
      u_core.xfer(1'b0, pfbw_pkg::ADDR_CONTROL, 32'h0, rd);
      chk("control busy", rd, {24'h0, CTL | GO});
      chk("stalled", stall, 1'b1);
      for (int k = 0; k < 200 && stall !== 1'b0; k++) @(posedge clk_i);
      if (stall !== 1'b0) begin
        miscompares++;
        finish_test();
      end
      chk("stall length", 64'(cyc_n - t0), 64'(WC));
      u_core.xfer(1'b0, pfbw_pkg::ADDR_CONTROL, 32'h0, rd);
      chk("control done", rd, {24'h0, CTL});
      u_core.xfer(1'b0, pfbw_pkg::ADDR_TBLPTR, 32'h0, rd);
      chk("pointer", rd, {18'h0, base + 14'h7});
      chk("blocks", n_blk, b + 1);
      chk("block address", f_addr, base);
      chk("block data", f_data, exp_q.pop_front());
    end
    // A finished launch leaves no unlock behind
    u_core.launch(CTL | GO);
    for (int k = 0; k < 200 && stall !== 1'b0; k++) @(posedge clk_i);
    chk("stall over", stall, 1'b0);
    u_core.xfer(1'b1, pfbw_pkg::ADDR_CONTROL, {24'h0, CTL | GO}, rd);
    chk("relaunch refused", n_blk, 9);
    finish_test();
  end
endmodule : pfbw_writer_tb
`default_nettype wire
